// ==== logic/otp_access_pkg.sv ====
// package for the secured otp access block: opcodes, otp map, lock-status layout, carriers
// assumes one core clock domain; link pins are sampled by the block itself
package otp_access_pkg;

  localparam logic [7:0] OP_ENTER_OTP = 8'hb1;
  localparam logic [7:0] OP_EXIT_OTP = 8'hc1;
  localparam logic [7:0] OP_READ_LOCK = 8'h2b;
  localparam logic [7:0] OP_WRITE_LOCK = 8'h2f;
  localparam logic [7:0] OP_WRITE_EN = 8'h06;
  localparam logic [7:0] OP_WRITE_SR1 = 8'h01;
  localparam logic [7:0] OP_WRITE_SR2 = 8'h31;
  localparam logic [7:0] OP_PROGRAM = 8'h02;
  localparam logic [7:0] OP_ERASE_4K = 8'h20;
  localparam logic [7:0] OP_READ = 8'h03;

  // otp map, byte addresses
  localparam int OTP_BITS = 4096;
  localparam int OTP_BYTES = OTP_BITS / 8;
  localparam int OTP_AW = 9;
  localparam logic [23:0] SERIAL_FIRST = 24'h000000;
  localparam logic [23:0] SERIAL_LAST = 24'h00000f;
  localparam logic [23:0] GENERAL_FIRST = 24'h000010;
  localparam logic [23:0] OTP_LAST = 24'h0001ff;

  // lock-status layout
  localparam int LOCK_FACTORY_BIT = 0;
  localparam int LOCK_CUSTOMER_BIT = 1;
  localparam logic [7:0] LOCK_STATUS_RST = 8'h00;
  localparam logic [7:0] OTP_ERASED = 8'hff;
  localparam int BYTE_BITS = 8;
  localparam int ADDR_BYTES = 3;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic mosi;
  } link_in_t;

  typedef struct packed {
    logic miso;
    logic miso_oe_n;
  } link_out_t;

  // request to the main-array core outside this block
  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic [23:0] addr;
  } array_req_t;

endpackage

// ==== logic/otp_mem.sv ====
// otp region storage: one write port, registered read data
// assumes the caller only writes bytes already cleared for writing
module otp_mem #(
  parameter int DEPTH = 512,
  parameter int AW = 9
) (
  input wire logic core_clk,
  input wire logic ce,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata
);
  import otp_access_pkg::*;

  logic [7:0] mem [DEPTH];

  // -----------------------------------------------
  // storage, erased state is all ones
  // -----------------------------------------------
  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      mem[i] = OTP_ERASED;
    end
  end

  always_ff @(posedge core_clk) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= mem[waddr] & wdata;
      end
      rdata <= mem[raddr];
    end
  end
endmodule // otp_mem

// ==== logic/secured_otp_access.sv ====
// serial command front end for the otp region and its lock-status register
// assumes spi mode 0 link sampled by core_clk; main array core sits outside
// Operation
// [R01] b1h enters otp mode, accesses go otp
// [R02] c1h leaves otp mode, main array again
// [R03] 2bh returns lock status always, repeatedly
// [R04] bit 0 shows factory lock
// [R05] bit 1 customer lock, settable once only; here reset clears it back to 0
// [R06] no otp program or erase once locked
// [R07] otp mode blocks main array writes
// [R08] 2fh needs no write enable first
// [R09] 2fh discarded unless cs rises on byte
// [R10] host enters, programs, then exits otp
// [R11] separate 4-kbit otp region
// [R12] serial field 0-f, general 10-1ff
// [R13] otp mode ignores status and lock writes
// [R14] locked otp accepts only reads
// [R15] bits 7-2 reserved, ignored
// [R16] otp program above region end ignored
module secured_otp_access #(
  parameter int OTP_DEPTH = otp_access_pkg::OTP_BYTES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire otp_access_pkg::link_in_t link_in,
  input wire logic factory_lock_in,
  input wire logic array_busy,
  output otp_access_pkg::link_out_t link_out,
  output otp_access_pkg::array_req_t array_req,
  output logic otp_mode,
  output logic [7:0] otp_lock_status
);
  import otp_access_pkg::*;

  typedef enum logic [2:0] {
    ST_OPCODE = 3'b000,
    ST_ADDR = 3'b001,
    ST_DATA_IN = 3'b010,
    ST_DATA_OUT = 3'b011,
    ST_WLOCK = 3'b100,
    ST_IGNORE = 3'b101
  } state_t;

  function automatic logic is_modify(input logic [7:0] op);
    return (op == OP_PROGRAM) || (op == OP_ERASE_4K);
  endfunction

  function automatic logic in_otp(input logic [23:0] a);
    return a <= OTP_LAST;
  endfunction

  // -----------------------------------------------
  // pin synchronisers and edge find
  // -----------------------------------------------
  link_in_t s1_q, s2_q, s3_q;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s1_q <= '{cs_n: 1'b1, sclk: 1'b0, mosi: 1'b0};
      s2_q <= '{cs_n: 1'b1, sclk: 1'b0, mosi: 1'b0};
      s3_q <= '{cs_n: 1'b1, sclk: 1'b0, mosi: 1'b0};
    end else if (ce) begin
      s1_q <= link_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  logic rise, fall, cs_rise, sel;
  assign sel = !s2_q.cs_n;
  assign rise = sel && s2_q.sclk && !s3_q.sclk;
  assign fall = sel && !s2_q.sclk && s3_q.sclk;
  assign cs_rise = s2_q.cs_n && !s3_q.cs_n;

  // -----------------------------------------------
  // factory strap synchroniser
  // -----------------------------------------------
  logic strap1_q, strap2_q;
  always_ff @(posedge core_clk) begin
    if (ce) begin
      strap1_q <= factory_lock_in;
      strap2_q <= strap1_q;
    end
  end

  // -----------------------------------------------
  // command state
  // -----------------------------------------------
  state_t st_q, st_d;
  logic [7:0] sh_q, sh_d, op_q, op_d, out_q, out_d;
  logic [2:0] bit_q, bit_d;
  logic [1:0] ab_q, ab_d;
  logic [23:0] addr_q, addr_d;
  logic mode_q, mode_d, wel_q, wel_d, cust_q, cust_d, fact_q, fact_d;
  logic fact_seen_q, fact_seen_d;
  logic miso_q, miso_d, oe_n_q, oe_n_d;
  logic [7:0] wl_q, wl_d;
  logic wl_pend_q, wl_pend_d;
  array_req_t req_q, req_d;
  logic mem_we;
  logic [7:0] mem_rdata;
  logic [8:0] byte_in;
  logic locked;

  assign byte_in = {sh_q[6:0], s2_q.mosi, 1'b0};
  assign locked = fact_q || cust_q;

  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    op_d = op_q;
    out_d = out_q;
    bit_d = bit_q;
    ab_d = ab_q;
    addr_d = addr_q;
    mode_d = mode_q;
    wel_d = wel_q;
    cust_d = cust_q;
    fact_d = fact_q;
    fact_seen_d = 1'b1;
    miso_d = miso_q;
    oe_n_d = oe_n_q;
    wl_d = wl_q;
    wl_pend_d = wl_pend_q;
    req_d = '0;
    mem_we = 1'b0;
    if (!fact_seen_q) begin
      fact_d = strap2_q; // [R04]
    end
    if (!sel) begin
      st_d = ST_OPCODE;
      bit_d = '0;
      oe_n_d = 1'b1;
      if (cs_rise && st_q == ST_WLOCK && wl_pend_q && bit_q == '0) begin // [R09]
        if (!mode_q && !cust_q && wl_q[LOCK_CUSTOMER_BIT]) begin // [R13]
          cust_d = 1'b1; // [R05] [R08] [R15]
        end
      end
      wl_pend_d = 1'b0;
    end else if (rise) begin
      sh_d = byte_in[8:1];
      bit_d = bit_q + 3'd1;
      if (bit_q == 3'd7) begin
        case (st_q)
          ST_OPCODE: begin
            op_d = byte_in[8:1];
            ab_d = '0;
            addr_d = '0;
            case (byte_in[8:1])
              OP_ENTER_OTP: begin
                mode_d = 1'b1; // [R01]
                st_d = ST_IGNORE;
              end
              OP_EXIT_OTP: begin
                mode_d = 1'b0; // [R02]
                st_d = ST_IGNORE;
              end
              OP_READ_LOCK: begin
                st_d = ST_DATA_OUT; // [R03]
                out_d = {6'h00, cust_q, fact_q};
              end
              OP_WRITE_LOCK: begin
                st_d = ST_WLOCK;
              end
              OP_WRITE_EN: begin
                wel_d = 1'b1;
                st_d = ST_IGNORE;
              end
              OP_WRITE_SR1, OP_WRITE_SR2: begin
                if (!mode_q) begin // [R13]
                  req_d = '{valid: 1'b1, opcode: byte_in[8:1], addr: '0};
                end
                st_d = ST_IGNORE;
              end
              OP_READ, OP_PROGRAM, OP_ERASE_4K: begin
                st_d = ST_ADDR;
              end
              default: begin
                if (!mode_q) begin
                  req_d = '{valid: 1'b1, opcode: byte_in[8:1], addr: '0};
                end
                st_d = ST_IGNORE;
              end
            endcase
          end
          ST_ADDR: begin
            addr_d = {addr_q[15:0], byte_in[8:1]};
            ab_d = ab_q + 2'd1;
            if (ab_q == 2'(ADDR_BYTES - 1)) begin
              if (!mode_q) begin
                if (!is_modify(op_q) || !array_busy) begin
                  req_d = '{valid: 1'b1, opcode: op_q, addr: addr_d};
                end
                st_d = ST_IGNORE;
              end else if (op_q == OP_READ) begin
                st_d = ST_DATA_OUT; // [R01]
              end else if (op_q == OP_PROGRAM && !locked && wel_q
                           && in_otp(addr_d)) begin // [R06] [R14] [R16]
                st_d = ST_DATA_IN;
              end else begin
                st_d = ST_IGNORE; // [R07]
              end
            end
          end
          ST_DATA_IN: begin
            mem_we = 1'b1; // [R10]
            addr_d = {15'h0000, addr_q[8:0] + 9'd1};
            if (addr_q == OTP_LAST) begin
              st_d = ST_IGNORE; // [R16]
            end
          end
          ST_WLOCK: begin
            wl_d = byte_in[8:1];
            wl_pend_d = 1'b1;
            if (wl_pend_q) begin
              st_d = ST_IGNORE; // [R09]
            end
          end
          default: begin
          end
        endcase
        if (st_q == ST_ADDR && ab_q == 2'(ADDR_BYTES - 1) && is_modify(op_q)) begin
          wel_d = 1'b0;
        end
      end
    end else if (fall) begin
      if (st_q == ST_DATA_OUT) begin
        oe_n_d = 1'b0;
        if (bit_q == '0) begin
          if (op_q == OP_READ_LOCK) begin
            out_d = {6'h00, cust_q, fact_q}; // [R03]
          end else begin
            out_d = mem_rdata;
            addr_d = {15'h0000, addr_q[8:0] + 9'd1}; // [R11] [R12]
          end
          miso_d = out_d[7];
        end else begin
          miso_d = out_q[3'd7 - bit_q];
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q <= ST_OPCODE;
      sh_q <= '0;
      op_q <= '0;
      out_q <= '0;
      bit_q <= '0;
      ab_q <= '0;
      addr_q <= '0;
      mode_q <= 1'b0;
      wel_q <= 1'b0;
      cust_q <= LOCK_STATUS_RST[LOCK_CUSTOMER_BIT];
      fact_q <= LOCK_STATUS_RST[LOCK_FACTORY_BIT];
      fact_seen_q <= 1'b0;
      miso_q <= 1'b0;
      oe_n_q <= 1'b1;
      wl_q <= '0;
      wl_pend_q <= 1'b0;
      req_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
      sh_q <= sh_d;
      op_q <= op_d;
      out_q <= out_d;
      bit_q <= bit_d;
      ab_q <= ab_d;
      addr_q <= addr_d;
      mode_q <= mode_d;
      wel_q <= wel_d;
      cust_q <= cust_d;
      fact_q <= fact_d;
      fact_seen_q <= fact_seen_d;
      miso_q <= miso_d;
      oe_n_q <= oe_n_d;
      wl_q <= wl_d;
      wl_pend_q <= wl_pend_d;
      req_q <= req_d;
    end
  end

  // -----------------------------------------------
  // otp storage
  // -----------------------------------------------
  otp_mem #(.DEPTH(OTP_DEPTH), .AW(OTP_AW)) u_mem (
    .core_clk(core_clk),
    .ce(ce),
    .we(mem_we),
    .waddr(addr_q[OTP_AW-1:0]),
    .wdata(byte_in[8:1]),
    .raddr(addr_q[OTP_AW-1:0]),
    .rdata(mem_rdata)
  );

  assign link_out = '{miso: miso_q, miso_oe_n: oe_n_q};
  assign array_req = req_q;
  assign otp_mode = mode_q;
  assign otp_lock_status = {6'h00, cust_q, fact_q}; // [R15]
endmodule // secured_otp_access

// ==== verif/secured_otp_access_asserts.sv ====
// port checker for the secured otp access block
// assumes one core clock domain, bound onto the top module
module secured_otp_access_asserts #(
  parameter int OTP_DEPTH = 512
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire otp_access_pkg::link_in_t link_in,
  input wire logic factory_lock_in,
  input wire logic array_busy,
  input wire otp_access_pkg::link_out_t link_out,
  input wire otp_access_pkg::array_req_t array_req,
  input wire logic otp_mode,
  input wire logic [7:0] otp_lock_status
);
  timeunit 1ns;
  timeprecision 1ps;
  import otp_access_pkg::*;
  // ----
  // properties
  // ----
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  sequence cs_idle;
    link_in.cs_n [*6];
  endsequence
  reserved_zero_a: assert property (otp_lock_status[7:2] == 6'h00)
    else $error("reserved lock bits set");
  factory_sticky_a: assert property (otp_lock_status[0] |=> otp_lock_status[0])
    else $error("factory lock bit cleared");
  customer_sticky_a: assert property (otp_lock_status[1] |=> otp_lock_status[1])
    else $error("customer lock bit cleared");
  lock_on_close_a: assert property ($rose(otp_lock_status[1])
    |-> link_in.cs_n && $past(link_in.cs_n, 2) && !otp_mode) else $error("lock set mid frame");
  mode_on_frame_a: assert property ($changed(otp_mode) |-> !$past(link_in.cs_n, 2))
    else $error("mode changed outside a frame");
  otp_write_block_a: assert property (otp_mode && array_req.valid
    |-> array_req.opcode != OP_PROGRAM && array_req.opcode != OP_ERASE_4K)
    else $error("array write in otp mode");
  otp_status_block_a: assert property (otp_mode && array_req.valid
    |-> array_req.opcode != OP_WRITE_SR1 && array_req.opcode != OP_WRITE_SR2)
    else $error("status write in otp mode");
  miso_release_a: assert property (cs_idle |-> link_out.miso_oe_n)
    else $error("miso driven while deselected");
endmodule // secured_otp_access_asserts

bind secured_otp_access secured_otp_access_asserts #(.OTP_DEPTH(OTP_DEPTH))
  u_secured_otp_access_asserts (.core_clk(core_clk), .rst(rst), .ce(ce), .link_in(link_in),
  .factory_lock_in(factory_lock_in), .array_busy(array_busy), .link_out(link_out),
  .array_req(array_req), .otp_mode(otp_mode), .otp_lock_status(otp_lock_status));

// ==== verif/secured_otp_access_bench.sv ====
// self-checking bench for the secured otp access block
// assumes the host model and the bound port checker
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module secured_otp_access_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import otp_access_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic factory_lock_in = 1'b0;
  logic array_busy = 1'b0;
  link_in_t link_in;
  link_out_t link_out;
  array_req_t array_req;
  array_req_t last_req;
  logic otp_mode;
  logic [7:0] otp_lock_status;
  logic [7:0] rx_byte;
  int fail_count = 0;
  int checks = 0;
  int wr_n = 0;
  // ----
  // harness
  // ----
  always #5 core_clk = ~core_clk;
  secured_otp_access #(.OTP_DEPTH(OTP_BYTES)) u_secured_otp_access (.core_clk(core_clk),
    .rst(rst), .ce(1'b1), .link_in(link_in), .factory_lock_in(factory_lock_in),
    .array_busy(array_busy), .link_out(link_out), .array_req(array_req),
    .otp_mode(otp_mode), .otp_lock_status(otp_lock_status));
  spi_host_model u_spi_host_model (.core_clk(core_clk), .link_in(link_in),
    .link_out(link_out));
  always @(posedge core_clk) begin
    if (array_req.valid === 1'b1) begin
      last_req <= array_req;
      if (array_req.opcode inside {OP_PROGRAM, OP_ERASE_4K, OP_WRITE_SR1, OP_WRITE_SR2}) wr_n++;
    end
  end
  task automatic xfer(input logic [7:0] b0, b1 = 0, b2 = 0, b3 = 0, b4 = 0,
    input int n = 1, input int tail = 0);
    u_spi_host_model.frame('{b0, b1, b2, b3, b4, 8'h00}, n, tail, rx_byte);
  endtask
  task automatic prog_read(input logic [23:0] a, input logic [7:0] d, e);
    xfer(OP_WRITE_EN);
    xfer(OP_PROGRAM, a[23:16], a[15:8], a[7:0], d, 5);
    xfer(OP_READ, a[23:16], a[15:8], a[7:0], 8'h00, 5);
    `CHK(rx_byte, e)
  endtask
  task automatic do_reset(input logic strap);
    factory_lock_in = strap;
    rst = 1'b1;
    repeat (10) @(negedge core_clk);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ----
  // tests
  // ----
  initial begin
    do_reset(1'b0);
    `CHK(otp_lock_status, 8'h00)
    array_busy = 1'b1;
    xfer(OP_READ_LOCK, , , , , 3);
    array_busy = 1'b0;
    `CHK(rx_byte, 8'h00)
    `CHK(link_out.miso_oe_n, 1'b1)
    xfer(OP_WRITE_EN);
    xfer(OP_PROGRAM, 8'h00, 8'h01, 8'h00, 8'ha5, 5);
    `CHK(last_req.addr, 24'h000100)
    `CHK(last_req.opcode, OP_PROGRAM)
    xfer(OP_ENTER_OTP);
    `CHK(otp_mode, 1'b1)
    prog_read(24'h00000f, 8'h3c, 8'h3c);
    prog_read(24'h000010, 8'hc3, 8'hc3);
    prog_read(24'h0001ff, 8'h5a, 8'h5a);
    prog_read(24'h000200, 8'h00, 8'hff);
    xfer(OP_WRITE_EN);
    xfer(OP_ERASE_4K, 8'h00, 8'h00, 8'h10, , 4);
    xfer(OP_READ, 8'h00, 8'h00, 8'h10, , 5);
    `CHK(rx_byte, 8'hc3)
    xfer(OP_WRITE_SR1, 8'h00, , , , 2);
    xfer(OP_WRITE_LOCK, 8'h02, , , , 2);
    `CHK(otp_lock_status, 8'h00)
    `CHK(wr_n, 1)
    xfer(OP_EXIT_OTP);
    `CHK(otp_mode, 1'b0)
    xfer(OP_READ, 8'h00, 8'h02, 8'h00, , 4);
    `CHK(last_req.addr, 24'h000200)
    `CHK(last_req.opcode, OP_READ)
    xfer(OP_WRITE_LOCK, 8'h02, 8'hff, , , 2, 3);
    `CHK(otp_lock_status, 8'h00)
    xfer(OP_WRITE_LOCK, 8'h02, 8'h02, , , 3);
    `CHK(otp_lock_status, 8'h00)
    xfer(OP_WRITE_LOCK, 8'hfe, , , , 2);
    `CHK(otp_lock_status, 8'h02)
    xfer(OP_WRITE_LOCK, 8'h00, , , , 2);
    xfer(OP_READ_LOCK, , , , , 4);
    `CHK(rx_byte, 8'h02)
    xfer(OP_ENTER_OTP);
    prog_read(24'h000020, 8'h00, 8'hff);
    xfer(OP_EXIT_OTP);
    do_reset(1'b1);
    `CHK(otp_lock_status[0], 1'b1)
    xfer(OP_ENTER_OTP);
    prog_read(24'h000030, 8'h00, 8'hff);
    tally_and_finish();
  end
  initial begin
    repeat (40000) @(posedge core_clk);
    fail_count++;
    tally_and_finish();
  end
endmodule // secured_otp_access_bench

// ==== verif/spi_host_model.sv ====
// host controller model driving the serial link in mode 0
// assumes the bench core clock; frames are started by the bench
module spi_host_model (
  input wire logic core_clk,
  output otp_access_pkg::link_in_t link_in,
  input wire otp_access_pkg::link_out_t link_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import otp_access_pkg::*;
  // ----
  // link driver
  // ----
  initial link_in = '{cs_n: 1'b1, sclk: 1'b0, mosi: 1'b0};
  // 160 ns bits, msb first, miso taken at the rising clock
  task automatic shift(input logic [7:0] tx, input int n, inout logic [7:0] rx);
    for (int i = 7; i > 7 - n; i--) begin
      @(negedge core_clk);
      link_in.mosi = tx[i];
      repeat (7) @(negedge core_clk);
      rx[i] = link_out.miso_oe_n ? ~link_out.miso : link_out.miso;
      link_in.sclk = 1'b1;
      repeat (8) @(negedge core_clk);
      link_in.sclk = 1'b0;
    end
  endtask
  task automatic frame(input logic [7:0] b[6], input int n, input int tail,
    output logic [7:0] rx);
    rx = 8'h00;
    @(negedge core_clk);
    link_in.cs_n = 1'b0;
    repeat (4) @(negedge core_clk);
    for (int k = 0; k < n; k++) shift(b[k], 8, rx);
    if (tail > 0) shift(b[n], tail, rx);
    repeat (4) @(negedge core_clk);
    link_in.cs_n = 1'b1;
    link_in.mosi = ~link_in.mosi;
    repeat (8) @(negedge core_clk);
  endtask
endmodule // spi_host_model
